// ---- core/mmf_defines.svh ----
`ifndef MMF_DEFINES_SVH
`define MMF_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define MMF_ADDR_CMD     8'h00
`define MMF_ADDR_RESP    8'h04
`define MMF_ADDR_IRQSTS  8'h08
`define MMF_ADDR_IRQMSK  8'h0C
`define MMF_ADDR_EVTPUSH 8'h10
`define MMF_ADDR_EVTBUF0 8'h20
`define MMF_ADDR_EVTBUF3 8'h2C

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define MMF_CODE_LSB     0
`define MMF_ARG_LSB      8
`define MMF_ARG2_LSB     16
`define MMF_BYTE_W       8

// Global enables bits
`define MMF_EN_RXQ       0
`define MMF_EN_EVTFULL   1
`define MMF_EN_EVTBUF    2
`define MMF_EN_SEL       3
`define MMF_EN_VEND0     5
`define MMF_EN_VEND1     6
`define MMF_EN_VEND2     7
`define MMF_EN_WMASK     8'h8F

// Message flag bits
`define MMF_FL_RXQ       0
`define MMF_FL_EVTFULL   1
`define MMF_FL_VEND0     5
`define MMF_FL_VEND1     6
`define MMF_FL_VEND2     7

// Interrupt status bits
`define MMF_IRQ_DONE     0
`define MMF_IRQ_EVTFULL  1
`define MMF_IRQ_DIAG     2
`define MMF_IRQ_W        3

// ----------------------------------------------------------------
// Completion codes and constants
// ----------------------------------------------------------------
`define MMF_CC_OK        8'h00
`define MMF_CC_NODATA    8'h80
`define MMF_CC_INVCMD    8'hC1
`define MMF_CC_BADFIELD  8'hCC
`define MMF_EVT_BYTES    16
`define MMF_EVT_PTR_W    4
`define MMF_EVT_LAST     4'hF
`define MMF_CH_W         4
`define MMF_CH_SUPPORTED 16'h0003
`define MMF_RESET_EN     8'h00
`define MMF_RESP_OKAY    2'b00
`define MMF_RESP_SLVERR  2'b10

`endif

// ---- core/mmf_pkg.sv ----
package mmf_pkg;

  typedef enum logic [7:0] {
    MMF_SET_GLOBAL_EN = 8'h2E,
    MMF_GET_GLOBAL_EN = 8'h2F,
    MMF_CLR_FLAGS     = 8'h30,
    MMF_GET_FLAGS     = 8'h31,
    MMF_EN_CH_RX      = 8'h32,
    MMF_GET_MSG       = 8'h33,
    MMF_SEND_MSG      = 8'h34,
    MMF_READ_EVT      = 8'h35,
    MMF_BT_CAPS       = 8'h36
  } mmf_cmd_t;

  typedef enum logic [1:0] {
    MMF_BUS_IDLE = 2'b00,
    MMF_BUS_TAKE = 2'b01,
    MMF_BUS_RESP = 2'b10
  } mmf_bus_t;

  typedef logic [7:0] mmf_byte_t;

endpackage

// ---- core/mmf_msg_flags.sv ----
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "mmf_defines.svh"

module mmf_msg_flags (
  input  wire logic              clk,
  input  wire logic              reset,
  // AXI4-Lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Device side
  input  wire logic              diagButton,
  input  wire logic              rxValid,
  input  wire logic [3:0]        rxChannel,
  input  wire mmf_pkg::mmf_byte_t rxByte,
  output logic                   txValid,
  output logic [3:0]             txChannel,
  output mmf_pkg::mmf_byte_t     txByte,
  output logic                   hostSwIrq,
  output logic                   fwModeSmi,
  output logic                   irq
);
  import mmf_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mmf_bus_t                    wrState;
  mmf_bus_t                    rdState;
  logic [7:0]                  wrAddr;
  logic [31:0]                 wrData;
  logic [3:0]                  wrStrb;
  logic [7:0]                  globalEn;
  logic                        diagFlag;
  logic                        diagPrev;
  logic                        rxqFull;
  logic [3:0]                  rxqChannel;
  mmf_byte_t                   rxqByte;
  mmf_byte_t                   evtMem [0:`MMF_EVT_BYTES-1];
  logic [`MMF_EVT_PTR_W-1:0]   evtPtr;
  logic                        evtFull;
  mmf_byte_t                   outMem [0:`MMF_EVT_BYTES-1];
  mmf_byte_t                   respCode;
  mmf_byte_t                   respData;
  mmf_byte_t                   respData2;
  logic [`MMF_IRQ_W-1:0]       irqStatus;
  logic [`MMF_IRQ_W-1:0]       irqMask;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        wrFire    = (wrState == MMF_BUS_TAKE);
  wire        rdFire    = (rdState == MMF_BUS_TAKE);
  wire        hitCmd    = (wrAddr == `MMF_ADDR_CMD);
  wire        hitWMask  = (wrAddr == `MMF_ADDR_IRQMSK);
  wire        hitPush   = (wrAddr == `MMF_ADDR_EVTPUSH);
  wire        wrMapped  = hitCmd || hitWMask || hitPush;
  wire        lowLane   = wrStrb[0];
  wire        cmdGo     = wrFire && hitCmd && lowLane;
  wire        pushGo    = wrFire && hitPush && lowLane;
  wire        maskGo    = wrFire && hitWMask && lowLane;

  wire        rdResp    = (s_axi_araddr == `MMF_ADDR_RESP);
  wire        rdSts     = (s_axi_araddr == `MMF_ADDR_IRQSTS);
  wire        rdMsk     = (s_axi_araddr == `MMF_ADDR_IRQMSK);
  wire        rdEvt     = (s_axi_araddr >= `MMF_ADDR_EVTBUF0) &&
                          (s_axi_araddr <= `MMF_ADDR_EVTBUF3) &&
                          (s_axi_araddr[1:0] == 2'b00);
  wire        rdMapped  = rdResp || rdSts || rdMsk || rdEvt;
  wire [1:0]  evtWord   = s_axi_araddr[3:2];
  wire        stsClear  = rdFire && rdSts;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire [7:0]  cmdCode   = wrData[`MMF_ARG_LSB-1:`MMF_CODE_LSB];
  wire [7:0]  cmdArg    = wrData[`MMF_ARG2_LSB-1:`MMF_ARG_LSB];
  wire [7:0]  cmdArg2   = wrData[`MMF_ARG2_LSB+`MMF_BYTE_W-1:`MMF_ARG2_LSB];
  wire [3:0]  sendCh    = cmdArg[`MMF_CH_W-1:0];
  wire [15:0] chMask    = `MMF_CH_SUPPORTED;
  wire        sendOk    = chMask[sendCh];
  wire        isSetEn   = cmdGo && (cmdCode == MMF_SET_GLOBAL_EN);
  wire        isGetEn   = cmdGo && (cmdCode == MMF_GET_GLOBAL_EN);
  wire        isClrFl   = cmdGo && (cmdCode == MMF_CLR_FLAGS);
  wire        isGetFl   = cmdGo && (cmdCode == MMF_GET_FLAGS);
  wire        isGetMsg  = cmdGo && (cmdCode == MMF_GET_MSG);
  wire        isSendMsg = cmdGo && (cmdCode == MMF_SEND_MSG);
  wire        isReadEvt = cmdGo && (cmdCode == MMF_READ_EVT);

  // Unsupported vendor bits are masked out on write, so reads show zero
  wire [7:0]  nextEn    = cmdArg & `MMF_EN_WMASK;

  // Only the real flags are visible; vendor zero and two always read zero
  wire [7:0]  flagsView = (8'(rxqFull)  << `MMF_FL_RXQ) |
                          (8'(evtFull)  << `MMF_FL_EVTFULL) |
                          (8'(diagFlag) << `MMF_FL_VEND1);

  // Clear requests for vendor zero and two have no term here
  wire        clrRxq    = isClrFl && cmdArg[`MMF_FL_RXQ];
  wire        clrEvt    = isClrFl && cmdArg[`MMF_FL_EVTFULL];
  wire        clrDiag   = isClrFl && cmdArg[`MMF_FL_VEND1];

  wire        getMsgOk  = isGetMsg && rxqFull;
  wire        readEvtOk = isReadEvt && evtFull;
  wire        diagPress = diagButton && !diagPrev;
  wire        evtWrite  = pushGo && !evtFull;
  wire        evtFills  = evtWrite && (evtPtr == `MMF_EVT_LAST);

  // Response code selection, anything else is an invalid command
  wire [7:0]  nextCode  =
    (isSetEn || isGetEn || isClrFl || isGetFl) ? `MMF_CC_OK :
    isGetMsg  ? (rxqFull ? `MMF_CC_OK : `MMF_CC_NODATA) :
    isSendMsg ? (sendOk ? `MMF_CC_OK : `MMF_CC_BADFIELD) :
    isReadEvt ? (evtFull ? `MMF_CC_OK : `MMF_CC_NODATA) :
    `MMF_CC_INVCMD;
  wire [7:0]  nextData  =
    isGetEn  ? globalEn :
    isGetFl  ? flagsView :
    getMsgOk ? rxqByte :
    8'h00;
  wire [7:0]  nextData2 = getMsgOk ? 8'(rxqChannel) : 8'h00;

  wire [`MMF_IRQ_W-1:0] irqEvents =
    ({{(`MMF_IRQ_W-1){1'b0}}, cmdGo} << `MMF_IRQ_DONE) |
    ({{(`MMF_IRQ_W-1){1'b0}}, evtFills} << `MMF_IRQ_EVTFULL) |
    ({{(`MMF_IRQ_W-1){1'b0}}, diagPress} << `MMF_IRQ_DIAG);
  // Set wins over the read-clear so no event is lost
  wire [`MMF_IRQ_W-1:0] next_irqStatus =
    (stsClear ? {`MMF_IRQ_W{1'b0}} : irqStatus) | irqEvents;

  wire [31:0] evtWordData = {outMem[{evtWord, 2'b11}], outMem[{evtWord, 2'b10}],
                             outMem[{evtWord, 2'b01}], outMem[{evtWord, 2'b00}]};
  wire [31:0] next_rdata =
    rdResp ? {8'h00, respData2, respData, respCode} :
    rdSts  ? {{(32-`MMF_IRQ_W){1'b0}}, irqStatus} :
    rdMsk  ? {{(32-`MMF_IRQ_W){1'b0}}, irqMask} :
    rdEvt  ? evtWordData :
    32'h0000_0000;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are each held until both have arrived
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wrState       <= MMF_BUS_IDLE;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MMF_RESP_OKAY;
      wrAddr        <= 8'h00;
      wrData        <= 32'h0000_0000;
      wrStrb        <= 4'h0;
    end
    else
    begin
      case (wrState)
        MMF_BUS_IDLE:
        begin
          if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready)
          begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
          end
          else if (s_axi_awready)
          begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            wrAddr        <= s_axi_awaddr;
            wrData        <= s_axi_wdata;
            wrStrb        <= s_axi_wstrb;
            wrState       <= MMF_BUS_TAKE;
          end
        end
        MMF_BUS_TAKE:
        begin
          s_axi_bvalid <= 1'b1;
          s_axi_bresp  <= wrMapped ? `MMF_RESP_OKAY : `MMF_RESP_SLVERR;
          wrState      <= MMF_BUS_RESP;
        end
        MMF_BUS_RESP:
        begin
          if (s_axi_bready)
          begin
            s_axi_bvalid <= 1'b0;
            wrState      <= MMF_BUS_IDLE;
          end
        end
        default:
          wrState <= MMF_BUS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rdState       <= MMF_BUS_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `MMF_RESP_OKAY;
    end
    else
    begin
      case (rdState)
        MMF_BUS_IDLE:
        begin
          if (s_axi_arvalid)
          begin
            s_axi_arready <= 1'b1;
            rdState       <= MMF_BUS_TAKE;
          end
        end
        MMF_BUS_TAKE:
        begin
          s_axi_arready <= 1'b0;
          s_axi_rvalid  <= 1'b1;
          s_axi_rdata   <= next_rdata;
          s_axi_rresp   <= rdMapped ? `MMF_RESP_OKAY : `MMF_RESP_SLVERR;
          rdState       <= MMF_BUS_RESP;
        end
        MMF_BUS_RESP:
        begin
          if (s_axi_rready)
          begin
            s_axi_rvalid <= 1'b0;
            rdState      <= MMF_BUS_IDLE;
          end
        end
        default:
          rdState <= MMF_BUS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command results and enables
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      globalEn  <= `MMF_RESET_EN;
      respCode  <= `MMF_CC_OK;
      respData  <= 8'h00;
      respData2 <= 8'h00;
    end
    else if (cmdGo)
    begin
      respCode  <= nextCode;
      respData  <= nextData;
      respData2 <= nextData2;
      if (isSetEn)
        globalEn <= nextEn;
    end
  end

  // ----------------------------------------------------------------
  // Message flags, receive slot and transmit
  // ----------------------------------------------------------------
  // No receive-enable state exists: only the supported channels 0 and 1 land in the slot
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      diagPrev   <= 1'b0;
      diagFlag   <= 1'b0;
      rxqFull    <= 1'b0;
      rxqChannel <= 4'h0;
      rxqByte    <= 8'h00;
      txValid    <= 1'b0;
      txChannel  <= 4'h0;
      txByte     <= 8'h00;
    end
    else
    begin
      diagPrev <= diagButton;
      if (diagPress)
        diagFlag <= 1'b1;
      else if (clrDiag)
        diagFlag <= 1'b0;
      if (rxValid && !rxqFull && chMask[rxChannel])
      begin
        rxqFull    <= 1'b1;
        rxqChannel <= rxChannel;
        rxqByte    <= rxByte;
      end
      else if (getMsgOk || clrRxq)
        rxqFull <= 1'b0;
      txValid <= isSendMsg && sendOk;
      if (isSendMsg && sendOk)
      begin
        txChannel <= sendCh;
        txByte    <= cmdArg2;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared event buffer
  // ----------------------------------------------------------------
  // Firmware pushes bytes; a full buffer refuses pushes until drained
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      evtPtr  <= `MMF_EVT_PTR_W'(0);
      evtFull <= 1'b0;
    end
    else if (evtWrite)
    begin
      evtPtr  <= evtPtr + `MMF_EVT_PTR_W'(1);
      evtFull <= evtFills;
    end
    else if (readEvtOk || clrEvt)
    begin
      evtFull <= 1'b0;
      evtPtr  <= `MMF_EVT_PTR_W'(0);
    end
  end

  wire [7:0] cmdArgPush = wrData[`MMF_BYTE_W-1:0];

  // Snapshot keeps returned data stable while the next event fills
  always_ff @(posedge clk)
  begin
    if (evtWrite)
      evtMem[evtPtr] <= cmdArgPush;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `MMF_EVT_BYTES; gi++)
    begin : gSnap
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
          outMem[gi] <= 8'h00;
        else if (readEvtOk)
          outMem[gi] <= evtMem[gi];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irqStatus <= {`MMF_IRQ_W{1'b0}};
      irqMask   <= {`MMF_IRQ_W{1'b0}};
      irq       <= 1'b0;
      hostSwIrq <= 1'b0;
      fwModeSmi <= 1'b0;
    end
    else
    begin
      irqStatus <= next_irqStatus;
      if (maskGo)
        irqMask <= wrData[`MMF_IRQ_W-1:0];
      irq       <= |(next_irqStatus & irqMask);
      hostSwIrq <= evtFull && globalEn[`MMF_EN_EVTFULL];
      fwModeSmi <= evtFull && globalEn[`MMF_EN_VEND2];
    end
  end

endmodule
`default_nettype wire

// ---- dv/mmf_msg_flags_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module mmf_msg_flags_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        txValid,
  input wire logic [3:0]  txChannel,
  input wire logic        hostSwIrq,
  input wire logic        fwModeSmi,
  input wire logic        irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  chk_aw_pair: assert property (s_axi_awready |-> s_axi_wready ##1 !s_axi_awready)
    else $error("awready not a single pulse with wready");
  chk_wr_answer: assert property (s_axi_awready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_bv_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  chk_rd_answer: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_rv_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before rready");
  chk_unmapped_err: assert property (s_axi_awready && s_axi_awaddr >= 8'h30 |-> ##2 s_axi_bresp == 2'b10)
    else $error("unmapped write not refused");
  chk_tx_pulse: assert property (txValid |=> !txValid)
    else $error("send pulse longer than one cycle");
  chk_tx_chan: assert property (txValid |-> txChannel < 4'h2)
    else $error("send on unsupported channel");
  chk_reset_quiet: assert property ($fell(reset) |-> !irq && !fwModeSmi && !hostSwIrq)
    else $error("interrupt active right after reset");

  cover property (txValid);
  cover property (fwModeSmi);
  cover property (hostSwIrq);
  cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
`default_nettype wire

// ---- dv/mmf_msg_peer.sv ----
`timescale 1ns/1ps
`default_nettype none

module mmf_msg_peer (
  input  wire logic               clk,
  input  wire logic               txValid,
  input  wire logic [3:0]         txChannel,
  input  wire mmf_pkg::mmf_byte_t txByte,
  output logic                    diagButton,
  output logic                    rxValid,
  output logic [3:0]              rxChannel,
  output mmf_pkg::mmf_byte_t      rxByte
);
  import mmf_pkg::*;
  int         txCount = 0;
  logic [3:0] lastCh = 4'h0;
  mmf_byte_t  lastByte = 8'h00;

  initial
  begin
    diagButton = 1'b0;
    rxValid = 1'b0;
    rxChannel = 4'h0;
    rxByte = 8'h00;
  end

  always @(posedge clk)
    if (txValid)
    begin
      txCount <= txCount + 1;
      lastCh <= txChannel;
      lastByte <= txByte;
    end

  task automatic press();
    @(posedge clk);
    diagButton <= 1'b1;
    repeat (2) @(posedge clk);
    diagButton <= 1'b0;
  endtask

  // Released lines show the inverse, never a stale byte
  task automatic send(input logic [3:0] ch, input mmf_byte_t b);
    @(posedge clk);
    rxValid <= 1'b1;
    rxChannel <= ch;
    rxByte <= b;
    @(posedge clk);
    rxValid <= 1'b0;
    rxChannel <= ~ch;
    rxByte <= ~b;
  endtask
endmodule
`default_nettype wire

// ---- dv/tb_mmf_msg_flags.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR %0t: got %0h want %0h", $time, (a), (b)); end end

module tb_mmf_msg_flags;
  import mmf_pkg::*;
  logic        clk = 1'b0, reset = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, txChannel;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        diagButton, rxValid, txValid, hostSwIrq, fwModeSmi, irq;
  logic [3:0]  rxChannel;
  mmf_byte_t   rxByte, txByte, cc;
  logic [15:0] dat;
  logic [31:0] rd;
  int          n_fail = 0, num_checks = 0, i;

  always #10 clk = ~clk;

  mmf_msg_flags dut_u (
    .clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .diagButton(diagButton), .rxValid(rxValid), .rxChannel(rxChannel), .rxByte(rxByte),
    .txValid(txValid), .txChannel(txChannel), .txByte(txByte), .hostSwIrq(hostSwIrq),
    .fwModeSmi(fwModeSmi), .irq(irq));

  mmf_msg_peer peer_u (
    .clk(clk), .txValid(txValid), .txChannel(txChannel), .txByte(txByte),
    .diagButton(diagButton), .rxValid(rxValid), .rxChannel(rxChannel), .rxByte(rxByte));

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready)
      begin
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic cmd(input mmf_byte_t code, input mmf_byte_t arg, input mmf_byte_t arg2);
    axw(8'h00, {8'h00, arg2, arg, code}, rs);
    axr(8'h04, rd, rs);
    cc = rd[7:0];
    dat = rd[23:8];
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    axr(8'h0C, rd, rs);
    `CHK(rd, 32'h0)
    // Only the diag event unmasked, so command-done never hides others
    axw(8'h0C, 32'h4, rs);
    axr(8'h0C, rd, rs);
    `CHK(rd, 32'h4)
    axw(8'h40, 32'hFF, rs);
    `CHK(rs, 2'b10)
    axr(8'h40, rd, rs);
    `CHK({rs, rd}, {2'b10, 32'h0})
    cmd(8'h2E, 8'hFF, 8'h00);
    `CHK(cc, 8'h00)
    cmd(8'h2F, 8'h00, 8'h00);
    `CHK(dat[7:0], 8'h8F)
    cmd(8'h2E, 8'h62, 8'h00);
    for (i = 0; i < 16; i++)
      axw(8'h10, 32'hA0 + i, rs);
    repeat (3) @(posedge clk);
    `CHK({hostSwIrq, fwModeSmi, irq}, 3'b100)
    cmd(8'h31, 8'h00, 8'h00);
    `CHK(dat[7:0], 8'h02)
    cmd(8'h2E, 8'h80, 8'h00);
    repeat (3) @(posedge clk);
    `CHK({hostSwIrq, fwModeSmi}, 2'b01)
    axw(8'h0C, 32'h6, rs);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b1)
    axr(8'h08, rd, rs);
    `CHK(rd[2:1], 2'b01)
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    axw(8'h0C, 32'h4, rs);
    cmd(8'h35, 8'h00, 8'h00);
    `CHK(cc, 8'h00)
    for (i = 0; i < 4; i++)
    begin
      axr(8'h20 + 4 * i, rd, rs);
      `CHK(rd, 32'hA3A2A1A0 + i * 32'h04040404)
    end
    cmd(8'h35, 8'h00, 8'h00);
    `CHK({cc, fwModeSmi}, {8'h80, 1'b0})
    peer_u.press();
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b1)
    cmd(8'h31, 8'h00, 8'h00);
    `CHK(dat[7:0], 8'h40)
    cmd(8'h30, 8'hA0, 8'h00);
    cmd(8'h31, 8'h00, 8'h00);
    `CHK(dat[7:0], 8'h40)
    cmd(8'h32, 8'hFF, 8'h00);
    `CHK(cc, 8'hC1)
    cmd(8'h36, 8'h00, 8'h00);
    `CHK(cc, 8'hC1)
    cmd(8'h31, 8'h00, 8'h00);
    `CHK(dat[7:0], 8'h40)
    cmd(8'h30, 8'h40, 8'h00);
    cmd(8'h31, 8'h00, 8'h00);
    `CHK(dat[7:0], 8'h00)
    cmd(8'h2F, 8'h00, 8'h00);
    `CHK(dat[7:0], 8'h80)
    peer_u.send(4'h7, 8'h11);
    cmd(8'h33, 8'h00, 8'h00);
    `CHK(cc, 8'h80)
    peer_u.send(4'h1, 8'hA5);
    cmd(8'h31, 8'h00, 8'h00);
    `CHK(dat[7:0], 8'h01)
    cmd(8'h33, 8'h00, 8'h00);
    `CHK({cc, dat}, 24'h0001A5)
    cmd(8'h33, 8'h00, 8'h00);
    `CHK(cc, 8'h80)
    cmd(8'h34, 8'h01, 8'h5A);
    `CHK({cc, peer_u.lastCh, peer_u.lastByte}, 20'h0015A)
    cmd(8'h34, 8'h05, 8'h33);
    `CHK({cc, peer_u.txCount[3:0]}, 12'hCC1)
    wrap_up();
  end

  // A normal run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    $display("ERROR %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule

bind mmf_msg_flags mmf_msg_flags_chk chk_u (
  .clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .txValid(txValid),
  .txChannel(txChannel), .hostSwIrq(hostSwIrq), .fwModeSmi(fwModeSmi), .irq(irq));
`default_nettype wire
